// ---- rtl/udiv_unit.sv ----
module udiv_unit #(
   parameter int unsigned AW = 8
) (
   // Clock and reset.
   input  wire logic          core_clk_i,
   input  wire logic          srst_i,
   // APB slave port.
   input  wire logic          psel_i,
   input  wire logic          penable_i,
   input  wire logic          pwrite_i,
   input  wire logic [AW-1:0] paddr_i,
   input  wire logic [31:0]   pwdata_i,
   output logic      [31:0]   prdata_o,
   output logic               pready_o,
   output logic               pslverr_o,
   // Execution status.
   output logic               busy_o,
   output logic               done_o,
   output logic               trap_o,
   output logic               overflow_o
);
   localparam int unsigned W  = udiv_pkg::DATA_W;
   localparam int unsigned QW = udiv_pkg::WORD_Q_W;

   typedef struct packed {
      udiv_pkg::fsm_t                       st;
      logic [udiv_pkg::NUM_DREG-1:0][W-1:0] dreg;
      logic [15:0]                          opw;
      logic [15:0]                          extw;
      logic [W-1:0]                         src;
      logic [4:0]                           ccr;
      logic                                 done;
      logic                                 trap;
      logic                                 illg;
      logic [W-1:0]                         rdata;
   } unit_t;

   unit_t          s_reg;
   unit_t          s_next;

   logic           word_form;
   logic           long_form;
   logic           size64;
   logic           ea_ok;
   logic [2:0]     qsel;
   logic [2:0]     rsel;
   logic           legal;
   logic [W-1:0]   divisor;
   logic [2*W-1:0] dividend;
   logic           div_zero;
   logic           pre_ovf;
   logic           word_ovf;
   logic           res_zero;
   logic           res_neg;
   logic           launch;
   logic           core_busy;
   logic           core_done;
   logic [W-1:0]   core_quot;
   logic [W-1:0]   core_rem;
   logic           acc;
   logic           wr_acc;
   logic           start;
   logic [W-1:0]   stat_word;

   // Data register window, aligned words only.
   function automatic logic is_dreg(input logic [AW-1:0] a);
      is_dreg = (a >= AW'(udiv_pkg::OFS_DREG)) && (a < AW'(udiv_pkg::OFS_DREG_END)) &&
                (a[1:0] == 2'b00);
   endfunction

   // Every address that answers without an error.
   function automatic logic mapped(input logic [AW-1:0] a);
      mapped = is_dreg(a) || (a == AW'(udiv_pkg::OFS_CTRL)) ||
               (a == AW'(udiv_pkg::OFS_OPWORD)) || (a == AW'(udiv_pkg::OFS_EXTWORD)) ||
               (a == AW'(udiv_pkg::OFS_SRC)) || (a == AW'(udiv_pkg::OFS_STATUS)) ||
               (a == AW'(udiv_pkg::OFS_CCR));
   endfunction

   // Instruction field decode.
   udiv_decode u_decode (
      .op_word_i           (s_reg.opw),
      .ext_word_i          (s_reg.extw),
      .word_form_o         (word_form),
      .long_form_o         (long_form),
      .dividend_size_bit_o (size64),
      .quot_sel_o          (qsel),
      .remainder_reg_o     (rsel),
      .ea_ok_o             (ea_ok)
   );

   // Operand selection and the checks made before any division starts.
   assign legal    = ea_ok & (word_form | long_form);
   assign divisor  = word_form ? {{(W-QW){1'b0}}, s_reg.src[QW-1:0]} : s_reg.src;
   assign dividend = (long_form & size64) ? {s_reg.dreg[rsel], s_reg.dreg[qsel]}
                                          : {{W{1'b0}}, s_reg.dreg[qsel]};
   assign div_zero = (divisor == '0);
   // A 64-bit dividend whose high word reaches the divisor cannot give a
   // 32-bit quotient; catching it here skips the whole iteration.
   assign pre_ovf  = (dividend[2*W-1:W] >= divisor);
   assign word_ovf = word_form & (core_quot[W-1:QW] != '0);

   // Result flags for the finished quotient.
   assign res_zero = word_form ? (core_quot[QW-1:0] == '0) : (core_quot == '0);
   assign res_neg  = word_form ? core_quot[QW-1] : core_quot[W-1];

   // Iterative divider.
   udiv_core #(
      .W (W)
   ) u_core (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .start_i    (launch),
      .dividend_i (dividend),
      .divisor_i  (divisor),
      .busy_o     (core_busy),
      .done_o     (core_done),
      .quot_o     (core_quot),
      .rem_o      (core_rem)
   );

   // Bus qualifiers; every write is refused while a division runs so that
   // software cannot race the result write-back.
   assign acc       = psel_i & penable_i;
   assign wr_acc    = acc & pwrite_i & mapped(paddr_i) & (s_reg.st == udiv_pkg::ST_IDLE);
   assign start     = wr_acc & (paddr_i == AW'(udiv_pkg::OFS_CTRL)) &
                      pwdata_i[udiv_pkg::CTRL_START_BIT];
   assign pready_o  = 1'b1;
   assign pslverr_o = acc & (!mapped(paddr_i) | (pwrite_i & busy_o));

   // Status word as software reads it.
   always_comb begin
      stat_word = '0;
      stat_word[udiv_pkg::STAT_BUSY_BIT] = busy_o;
      stat_word[udiv_pkg::STAT_DONE_BIT] = s_reg.done;
      stat_word[udiv_pkg::STAT_TRAP_BIT] = s_reg.trap;
      stat_word[udiv_pkg::STAT_ILL_BIT]  = s_reg.illg;
   end

   // Next state: bus reads and writes, then the instruction sequencer.
   always_comb begin
      s_next = s_reg;
      launch = 1'b0;
      // Read data is captured in the setup phase and stands in the access phase.
      if (psel_i && !penable_i) begin
         case (paddr_i)
            AW'(udiv_pkg::OFS_OPWORD):  s_next.rdata = {16'h0000, s_reg.opw};
            AW'(udiv_pkg::OFS_EXTWORD): s_next.rdata = {16'h0000, s_reg.extw};
            AW'(udiv_pkg::OFS_SRC):     s_next.rdata = s_reg.src;
            AW'(udiv_pkg::OFS_STATUS):  s_next.rdata = stat_word;
            AW'(udiv_pkg::OFS_CCR):     s_next.rdata = {27'h0000000, s_reg.ccr};
            default: begin
               if (is_dreg(paddr_i)) begin
                  s_next.rdata = s_reg.dreg[paddr_i[4:2]];
               end else begin
                  s_next.rdata = '0;
               end
            end
         endcase
      end
      // Software writes; control and status writes store nothing.
      if (wr_acc) begin
         case (paddr_i)
            AW'(udiv_pkg::OFS_OPWORD):  s_next.opw  = pwdata_i[15:0];
            AW'(udiv_pkg::OFS_EXTWORD): s_next.extw = pwdata_i[15:0];
            AW'(udiv_pkg::OFS_SRC):     s_next.src  = pwdata_i;
            AW'(udiv_pkg::OFS_CCR):     s_next.ccr  = pwdata_i[4:0];
            default: begin
               if (is_dreg(paddr_i)) begin
                  s_next.dreg[paddr_i[4:2]] = pwdata_i;
               end
            end
         endcase
      end
      // Sequencer; the extend bit is never touched here.
      case (s_reg.st)
         udiv_pkg::ST_IDLE: begin
            if (start) begin
               s_next.done = 1'b0;
               s_next.trap = 1'b0;
               s_next.illg = 1'b0;
               if (!legal) begin
                  s_next.illg = 1'b1;
                  s_next.done = 1'b1;
               end else if (div_zero) begin
                  s_next.trap = 1'b1;
                  s_next.done = 1'b1;
                  s_next.ccr[udiv_pkg::CC_V] = 1'b0;
                  s_next.ccr[udiv_pkg::CC_C] = 1'b0;
               end else if (pre_ovf) begin
                  s_next.ccr[udiv_pkg::CC_V] = 1'b1;
                  s_next.ccr[udiv_pkg::CC_C] = 1'b0;
                  s_next.done = 1'b1;
               end else begin
                  launch = 1'b1;
                  s_next.st = udiv_pkg::ST_RUN;
               end
            end
         end
         udiv_pkg::ST_RUN: begin
            if (core_done) begin
               s_next.st   = udiv_pkg::ST_IDLE;
               s_next.done = 1'b1;
               s_next.ccr[udiv_pkg::CC_C] = 1'b0;
               if (word_ovf) begin
                  s_next.ccr[udiv_pkg::CC_V] = 1'b1;
               end else begin
                  s_next.ccr[udiv_pkg::CC_V] = 1'b0;
                  s_next.ccr[udiv_pkg::CC_N] = res_neg;
                  s_next.ccr[udiv_pkg::CC_Z] = res_zero;
                  if (word_form) begin
                     s_next.dreg[qsel] = {core_rem[QW-1:0], core_quot[QW-1:0]};
                  end else begin
                     s_next.dreg[qsel] = core_quot;
                     if (rsel != qsel) begin
                        s_next.dreg[rsel] = core_rem;
                     end
                  end
               end
            end
         end
         default: begin
            s_next.st = udiv_pkg::ST_IDLE;
         end
      endcase
   end

   // State register with reset values.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_reg      <= '0;
         s_reg.st   <= udiv_pkg::ST_IDLE;
         s_reg.ccr  <= udiv_pkg::CCR_RST;
         s_reg.dreg <= {udiv_pkg::NUM_DREG{udiv_pkg::DREG_RST}};
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs.
   assign prdata_o   = s_reg.rdata;
   assign busy_o     = (s_reg.st == udiv_pkg::ST_RUN);
   assign done_o     = s_reg.done;
   assign trap_o     = s_reg.trap;
   assign overflow_o = s_reg.ccr[udiv_pkg::CC_V];

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_issue;
      (s_reg.st == udiv_pkg::ST_IDLE) && start;
   endsequence

   sequence s_launch;
      s_issue and (legal && !div_zero && !pre_ovf);
   endsequence

   sequence s_finish;
      (s_reg.st == udiv_pkg::ST_RUN) && core_done;
   endsequence

   a_run_length: assert property (
      s_launch |=> busy_o [*8] ##25 s_finish ##1 (done_o && !busy_o))
      else $error("Division did not complete in the expected cycles.");

   a_zero_trap: assert property (
      (s_issue and (legal && div_zero)) |=>
         trap_o && done_o && !busy_o && (s_reg.dreg == $past(s_reg.dreg)))
      else $error("Zero divisor did not trap cleanly.");

   a_early_overflow: assert property (
      (s_issue and (legal && !div_zero && pre_ovf)) |=>
         overflow_o && !busy_o && (s_reg.dreg == $past(s_reg.dreg)))
      else $error("Early overflow changed operands or missed the flag.");

   a_word_overflow: assert property (
      (s_finish and word_ovf) |=>
         overflow_o && !s_reg.ccr[udiv_pkg::CC_C] && (s_reg.dreg == $past(s_reg.dreg)))
      else $error("Word overflow changed operands or missed the flag.");

   a_word_result: assert property (
      (s_finish and (word_form && !word_ovf)) |=>
         s_reg.dreg[$past(qsel)] == {$past(core_rem[QW-1:0]), $past(core_quot[QW-1:0])})
      else $error("Word form result placed wrongly.");

   a_long_pair: assert property (
      (s_finish and (long_form && rsel != qsel)) |=>
         (s_reg.dreg[$past(qsel)] == $past(core_quot)) &&
         (s_reg.dreg[$past(rsel)] == $past(core_rem)))
      else $error("Long form quotient or remainder missing.");

   a_same_reg: assert property (
      (s_finish and (long_form && rsel == qsel)) |=>
         s_reg.dreg[$past(qsel)] == $past(core_quot))
      else $error("Equal register fields did not keep the quotient.");

   a_result_flags: assert property (
      (s_finish and !word_ovf) |=>
         (s_reg.ccr[udiv_pkg::CC_Z] == $past(res_zero)) &&
         (s_reg.ccr[udiv_pkg::CC_N] == $past(res_neg)) && !overflow_o)
      else $error("Negative or zero flag wrong after division.");

   a_carry_extend: assert property (
      // An illegal instruction never executes, so it leaves the carry as it was.
      (done_o && !$past(done_o) && !$past(wr_acc) && !s_reg.illg) |->
         !s_reg.ccr[udiv_pkg::CC_C] && $stable(s_reg.ccr[udiv_pkg::CC_X]))
      else $error("Carry not cleared or extend bit disturbed.");

   a_illegal_mode: assert property (
      (s_issue and !legal) |=>
         s_reg.illg && done_o && !busy_o && (s_reg.dreg == $past(s_reg.dreg)))
      else $error("Illegal source mode was not refused.");

   // The finishing cycle is left out, since the result write-back lands there.
   a_busy_refuse: assert property (
      (acc && pwrite_i && busy_o && !core_done) |-> pslverr_o ##1 $stable(s_reg.dreg))
      else $error("Write during a division was not refused.");
endmodule // udiv_unit

// ---- rtl/udiv_pkg.sv ----
package udiv_pkg;
   // Datapath sizes.
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned NUM_DREG  = 8;
   localparam int unsigned WORD_Q_W  = 16;
   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_OPWORD  = 8'h04;
   localparam logic [7:0] OFS_EXTWORD = 8'h08;
   localparam logic [7:0] OFS_SRC     = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_CCR     = 8'h14;
   localparam logic [7:0] OFS_DREG    = 8'h20;
   localparam logic [7:0] OFS_DREG_END = 8'h40;
   // Control, status and condition code bit positions.
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT  = 0;
   localparam int unsigned STAT_DONE_BIT  = 1;
   localparam int unsigned STAT_TRAP_BIT  = 2;
   localparam int unsigned STAT_ILL_BIT   = 3;
   localparam int unsigned CC_C = 0;
   localparam int unsigned CC_V = 1;
   localparam int unsigned CC_Z = 2;
   localparam int unsigned CC_N = 3;
   localparam int unsigned CC_X = 4;
   // Reset values.
   localparam logic [4:0]  CCR_RST  = 5'h00;
   localparam logic [31:0] DREG_RST = 32'h0000_0000;
   // Opcode and extension word fields.
   localparam int unsigned WORD_GRP_LSB = 12;
   localparam logic [3:0]  WORD_GRP     = 4'h8;
   localparam int unsigned WORD_OPM_LSB = 6;
   localparam logic [2:0]  WORD_OPM     = 3'h3;
   localparam int unsigned DREG_FLD_LSB = 9;
   localparam int unsigned LONG_OP_LSB  = 6;
   localparam logic [9:0]  LONG_OP      = 10'h131;
   localparam int unsigned EA_MODE_LSB  = 3;
   localparam int unsigned EA_REG_LSB   = 0;
   localparam int unsigned EXT_Q_LSB    = 12;
   localparam int unsigned EXT_SGN_BIT  = 11;
   localparam int unsigned EXT_SIZE_BIT = 10;
   localparam int unsigned EXT_R_LSB    = 0;
   // Source addressing mode codes.
   localparam logic [2:0] EA_MODE_AREG = 3'h1;
   localparam logic [2:0] EA_MODE_EXT  = 3'h7;
   localparam logic [2:0] EA_ABS_W     = 3'h0;
   localparam logic [2:0] EA_ABS_L     = 3'h1;
   localparam logic [2:0] EA_PC_DISP   = 3'h2;
   localparam logic [2:0] EA_PC_IDX    = 3'h3;
   localparam logic [2:0] EA_IMM       = 3'h4;
   // Sequencer states.
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } fsm_t;
endpackage

// ---- rtl/udiv_decode.sv ----
module udiv_decode (
   // Instruction words.
   input  wire logic [15:0] op_word_i,
   input  wire logic [15:0] ext_word_i,
   // Decoded fields.
   output logic             word_form_o,
   output logic             long_form_o,
   output logic             dividend_size_bit_o,
   output logic [2:0]       quot_sel_o,
   output logic [2:0]       remainder_reg_o,
   output logic             ea_ok_o
);
   // Mode seven subcodes above the immediate form have no meaning as a source.
   function automatic logic ea_legal(input logic [2:0] mode, input logic [2:0] rs);
      ea_legal = 1'b1;
      if (mode == udiv_pkg::EA_MODE_AREG) begin
         ea_legal = 1'b0;
      end else if (mode == udiv_pkg::EA_MODE_EXT) begin
         ea_legal = (rs == udiv_pkg::EA_ABS_W) | (rs == udiv_pkg::EA_ABS_L) |
                    (rs == udiv_pkg::EA_PC_DISP) | (rs == udiv_pkg::EA_PC_IDX) |
                    (rs == udiv_pkg::EA_IMM);
      end
   endfunction

   // Field extraction; the signed select bit must be clear for this unit.
   assign word_form_o = (op_word_i[udiv_pkg::WORD_GRP_LSB +: 4] == udiv_pkg::WORD_GRP) &&
                        (op_word_i[udiv_pkg::WORD_OPM_LSB +: 3] == udiv_pkg::WORD_OPM);
   assign long_form_o = (op_word_i[udiv_pkg::LONG_OP_LSB +: 10] == udiv_pkg::LONG_OP) &&
                        !ext_word_i[udiv_pkg::EXT_SGN_BIT];
   assign dividend_size_bit_o = ext_word_i[udiv_pkg::EXT_SIZE_BIT];
   assign quot_sel_o = word_form_o ? op_word_i[udiv_pkg::DREG_FLD_LSB +: 3]
                                   : ext_word_i[udiv_pkg::EXT_Q_LSB +: 3];
   assign remainder_reg_o = ext_word_i[udiv_pkg::EXT_R_LSB +: 3];
   assign ea_ok_o = ea_legal(op_word_i[udiv_pkg::EA_MODE_LSB +: 3],
                             op_word_i[udiv_pkg::EA_REG_LSB +: 3]);
endmodule // udiv_decode

// ---- rtl/udiv_core.sv ----
module udiv_core #(
   parameter int unsigned W = udiv_pkg::DATA_W
) (
   // Clock and reset.
   input  wire logic           core_clk_i,
   input  wire logic           srst_i,
   // Request.
   input  wire logic           start_i,
   input  wire logic [2*W-1:0] dividend_i,
   input  wire logic [W-1:0]   divisor_i,
   // Result.
   output logic                busy_o,
   output logic                done_o,
   output logic [W-1:0]        quot_o,
   output logic [W-1:0]        rem_o
);
   localparam int unsigned CW = $clog2(W) + 1;

   typedef struct packed {
      logic          busy;
      logic          done;
      logic [CW-1:0] cnt;
      logic [W-1:0]  rem;
      logic [W-1:0]  quo;
      logic [W-1:0]  den;
   } core_t;

   core_t        s_reg;
   core_t        s_next;
   logic [W:0]   trial;
   logic [2*W-1:0] dvd_hold;

   // Restoring division, one quotient bit a cycle; the caller guarantees the
   // high dividend word is below the divisor, so the quotient fits W bits.
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      trial = {s_reg.rem, s_reg.quo[W-1]};
      if (s_reg.busy) begin
         if (trial >= {1'b0, s_reg.den}) begin
            s_next.rem = W'(trial - {1'b0, s_reg.den});
            s_next.quo = {s_reg.quo[W-2:0], 1'b1};
         end else begin
            s_next.rem = trial[W-1:0];
            s_next.quo = {s_reg.quo[W-2:0], 1'b0};
         end
         s_next.cnt = s_reg.cnt - 1'b1;
         if (s_reg.cnt == CW'(1)) begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
         end
      end else if (start_i) begin
         s_next.busy = 1'b1;
         s_next.cnt  = CW'(W);
         s_next.rem  = dividend_i[2*W-1:W];
         s_next.quo  = dividend_i[W-1:0];
         s_next.den  = divisor_i;
      end
   end

   // State register.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Dividend copy kept only for the result check below.
   always_ff @(posedge core_clk_i) begin
      if (start_i && !s_reg.busy) begin
         dvd_hold <= dividend_i;
      end
   end

   assign busy_o = s_reg.busy;
   assign done_o = s_reg.done;
   assign quot_o = s_reg.quo;
   assign rem_o  = s_reg.rem;

   a_quotient_exact: assert property (@(posedge core_clk_i) disable iff (srst_i)
      done_o |-> ((2*W)'(quot_o) * (2*W)'(s_reg.den) + (2*W)'(rem_o) == dvd_hold) &&
                 (rem_o < s_reg.den))
      else $error("Quotient and remainder do not rebuild the dividend.");

   a_core_length: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (start_i && !busy_o) |=> busy_o [*8] ##24 (busy_o && !done_o) ##1 done_o)
      else $error("Division did not finish after the expected cycle count.");
endmodule // udiv_core

// ---- bench/udiv_issue_model.sv ----
module udiv_issue_model (
   // Clock.
   input  wire logic        core_clk_i,
   // APB master side.
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // The bus starts idle with no transfer pending.
   initial begin
      psel_o = 1'h0;
      penable_o = 1'h0;
      pwrite_o = 1'h0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
   end

   // Released address and data lines show the inverse, so a stale value can never pass as fresh.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge core_clk_i);
      psel_o    <= 1'h1;
      pwrite_o  <= w;
      paddr_o   <= a;
      pwdata_o  <= d;
      @(posedge core_clk_i);
      penable_o <= 1'h1;
      do @(posedge core_clk_i); while (pready_i !== 1'h1);
      rd = prdata_i;
      err = pslverr_i;
      psel_o    <= 1'h0;
      penable_o <= 1'h0;
      paddr_o   <= ~a;
      pwdata_o  <= ~d;
   endtask

   // Instruction word encoders as the decoder would issue them.
   function automatic logic [15:0] word_op(input logic [2:0] dn, input logic [5:0] ea);
      return {4'h8, dn, 3'h3, ea};
   endfunction
   function automatic logic [15:0] long_op(input logic [5:0] ea);
      return {10'h131, ea};
   endfunction
   function automatic logic [15:0] ext(input logic [2:0] q, input logic s, input logic [2:0] r);
      return {1'h0, q, 1'h0, s, 7'h00, r};
   endfunction
endmodule // udiv_issue_model

// ---- bench/tb_unsigned_divide_unit.sv ----
module tb_unsigned_divide_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i, srst_i, psel, penable, pwrite, pready, pslverr;
   logic        busy, done, trap, ovf, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          failures, samples_checked;

   udiv_unit dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .busy_o(busy),
      .done_o(done), .trap_o(trap), .overflow_o(ovf));
   udiv_issue_model bus (.core_clk_i(core_clk_i), .psel_o(psel), .penable_o(penable),
      .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
      .pready_i(pready), .pslverr_i(pslverr));

   // Free-running 250 MHz clock.
   initial begin
      core_clk_i = 1'h0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   task automatic finish_test;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [7:0] dreg(input logic [2:0] k);
      return udiv_pkg::OFS_DREG + {3'h0, k, 2'h0};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus.xfer(1'h1, a, d, rd, err);
   endtask

   task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
      bus.xfer(1'h0, a, 32'h0, rd, err);
      chk(name, rd, exp);
   endtask

   // Polling is bounded; a division still busy at the limit counts as a mismatch.
   task automatic poll;
      rd = 32'h1;
      for (int i = 0; i < 20 && rd[0]; i++) bus.xfer(1'h0, udiv_pkg::OFS_STATUS, 32'h0, rd, err);
      chk("poll_idle", {31'h0, rd[0]}, 32'h0);
   endtask

   // Loads one instruction, starts it and waits for it to end.
   task automatic run(input logic [15:0] op, input logic [15:0] ex, input logic [31:0] s);
      wr(udiv_pkg::OFS_OPWORD, {16'h0, op});
      wr(udiv_pkg::OFS_EXTWORD, {16'h0, ex});
      wr(udiv_pkg::OFS_SRC, s);
      wr(udiv_pkg::OFS_CTRL, 32'h1);
      poll;
   endtask

   // Main sequence: reset, then one instruction per form and per special case.
   initial begin
      srst_i = 1'h1;
      repeat (4) @(posedge core_clk_i);
      srst_i <= 1'h0;
      rdc("ccr_rst", udiv_pkg::OFS_CCR, 32'h0);
      rdc("d5_rst", dreg(3'h5), 32'h0);
      wr(udiv_pkg::OFS_CCR, 32'h11);
      wr(dreg(3'h3), 32'h64);
      run(bus.word_op(3'h3, 6'h00), 16'h0, 32'h7);
      chk("stat_ok", rd, 32'h2);
      rdc("d3_word", dreg(3'h3), 32'h0002_000E);
      rdc("ccr_word", udiv_pkg::OFS_CCR, 32'h10);
      wr(dreg(3'h0), 32'h3);
      run(bus.word_op(3'h0, 6'h3C), 16'h0, 32'h7);
      rdc("d0_zero", dreg(3'h0), 32'h0003_0000);
      rdc("ccr_zero", udiv_pkg::OFS_CCR, 32'h14);
      wr(dreg(3'h1), 32'h0010_0000);
      run(bus.word_op(3'h1, 6'h39), 16'h0, 32'h1);
      rdc("d1_ovf", dreg(3'h1), 32'h0010_0000);
      rdc("ccr_ovf", udiv_pkg::OFS_CCR, 32'h16);
      chk("ovf_pin", {31'h0, ovf}, 32'h1);
      run(bus.word_op(3'h1, 6'h00), 16'h0, 32'h0001_0000);
      chk("stat_trap", rd, 32'h6);
      rdc("d1_trap", dreg(3'h1), 32'h0010_0000);
      rdc("ccr_trap", udiv_pkg::OFS_CCR, 32'h14);
      chk("trap_pin", {31'h0, trap}, 32'h1);
      wr(dreg(3'h2), 32'hFFFF_FFFF);
      run(bus.long_op(6'h3A), bus.ext(3'h2, 1'h0, 3'h2), 32'h1);
      rdc("d2_q", dreg(3'h2), 32'hFFFF_FFFF);
      rdc("ccr_neg", udiv_pkg::OFS_CCR, 32'h18);
      wr(dreg(3'h4), 32'h64);
      wr(dreg(3'h5), 32'hA5A5_A5A5);
      run(bus.long_op(6'h3B), bus.ext(3'h4, 1'h0, 3'h5), 32'h7);
      rdc("d4_q", dreg(3'h4), 32'hE);
      rdc("d5_r", dreg(3'h5), 32'h2);
      // Restart the same instruction and try to write while it runs.
      wr(udiv_pkg::OFS_CTRL, 32'h1);
      bus.xfer(1'h1, dreg(3'h4), 32'h55, rd, err);
      chk("busy_err", {31'h0, err}, 32'h1);
      chk("busy_pin", {31'h0, busy}, 32'h1);
      poll;
      chk("done_pin", {31'h0, done}, 32'h1);
      rdc("d4_busy", dreg(3'h4), 32'h2);
      rdc("d5_busy", dreg(3'h5), 32'h0);
      wr(dreg(3'h7), 32'h1);
      wr(dreg(3'h6), 32'h0);
      run(bus.long_op(6'h10), bus.ext(3'h6, 1'h1, 3'h7), 32'h2);
      rdc("d6_q64", dreg(3'h6), 32'h8000_0000);
      rdc("d7_r64", dreg(3'h7), 32'h0);
      // High dividend word above the divisor overflows before any iteration.
      wr(dreg(3'h7), 32'h5);
      run(bus.long_op(6'h00), bus.ext(3'h6, 1'h1, 3'h7), 32'h2);
      chk("stat_pre", rd, 32'h2);
      rdc("d6_pre", dreg(3'h6), 32'h8000_0000);
      rdc("d7_pre", dreg(3'h7), 32'h5);
      rdc("ccr_pre", udiv_pkg::OFS_CCR, 32'h1A);
      run(bus.word_op(3'h0, 6'h08), 16'h0, 32'h1);
      chk("stat_ill", rd, 32'hA);
      chk("ill_done", {31'h0, done}, 32'h1);
      run(bus.word_op(3'h0, 6'h3D), 16'h0, 32'h1);
      chk("stat_ea", rd, 32'hA);
      run(bus.long_op(6'h00), 16'h0800, 32'h1);
      chk("stat_sgn", rd, 32'hA);
      bus.xfer(1'h1, 8'h18, 32'h1, rd, err);
      chk("unmapped", {31'h0, err}, 32'h1);
      finish_test;
   end

   // Watchdog well beyond the few hundred cycles the sequence needs.
   initial begin
      #(4 * 20000);
      failures++;
      finish_test;
   end
endmodule // tb_unsigned_divide_unit
